// [mtc_edge_det.sv]
`timescale 1ns/1ps
// Purpose: rising edge detector for the start bit
// Assumes: level synchronous to the clock
// Notes: edges while busy are dropped
module mtc_edge_det (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // edge carrier
  mtc_edge_if.det eif
);
  logic prev;

  // previous sample held for compare
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      prev <= 1'b0;
    end else begin
      prev <= eif.level;
    end
  end

  assign eif.rise = eif.level && !prev && !eif.busy;

  property p_edge_only;
    @(posedge i_ref_clk) disable iff (i_srst)
      eif.rise |-> !$past(eif.level);
  endproperty
  a_edge_only: assert property (p_edge_only) else $error("start without 0 to 1");
endmodule

// [mtc_edge_if.sv]
`timescale 1ns/1ps
// Purpose: carries the start bit sample and the qualified edge
// Assumes: one clock
// Notes: used between the top and its edge detector
interface mtc_edge_if;
  logic level;
  logic busy;
  logic rise;
  modport det (input level, input busy, output rise);
  modport top (output level, output busy, input rise);
endinterface

// [mtc_master.sv]
`timescale 1ns/1ps
// Purpose: fieldbus master model issuing object reads and writes
// Assumes: strobe taken on a rising edge, answer one cycle later
// Notes: released index and data lines carry the inverse of the last request; sub-index is kept
module mtc_master (
  // clock
  input wire logic i_ref_clk,
  // answer from the block
  input wire logic [31:0] i_rdata,
  input wire logic i_ack,
  input wire logic i_abort,
  input wire logic [31:0] i_abort_code,
  // request to the block
  output logic o_wr,
  output logic o_rd,
  output logic [15:0] o_index,
  output logic [7:0] o_sub,
  output logic [31:0] o_wdata
);
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_index = 16'h0000;
    o_sub = 8'h00;
    o_wdata = 32'h0000_0000;
  end
  // one access: strobe for one cycle, answer taken the cycle after
  task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                        input logic [31:0] data, output logic [31:0] rdata,
                        output logic ack, output logic abort, output logic [31:0] code);
    @(posedge i_ref_clk);
    o_wr <= wr;
    o_rd <= ~wr;
    o_index <= idx;
    o_sub <= sub;
    o_wdata <= data;
    @(posedge i_ref_clk);
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    o_index <= ~idx;
    o_wdata <= ~data;
    #1;
    rdata = i_rdata;
    ack = i_ack;
    abort = i_abort;
    code = i_abort_code;
  endtask
endmodule

// [mtc_pkg.sv]
// Purpose: constants for the multi-turn clear trigger
// Assumes: one control clock, synchronous active-high reset
// Notes: object indices and sub-indices are kept as named constants
package mtc_pkg;
  localparam logic [15:0] IDX_START = 16'h4D00;
  localparam logic [15:0] IDX_SETTING = 16'h4D01;
  localparam logic [7:0] SUB_COUNT = 8'h00;
  localparam logic [7:0] SUB_FLAGS_A = 8'h01;
  localparam logic [7:0] SUB_FLAGS_B = 8'h02;
  localparam logic [7:0] SUB_MAKER = 8'h03;
  localparam logic [7:0] ENTRY_COUNT = 8'h03;
  localparam int START_BIT = 9;
  localparam int ATTAINED_BIT = 12;
  localparam logic [15:0] FN_NONE = 16'h0000;
  localparam logic [15:0] FN_MT_CLEAR = 16'h0031;
  localparam logic [31:0] ABORT_STATE = 32'h0800_0022;
  localparam logic [31:0] ABORT_NO_OBJECT = 32'h0602_0000;
  localparam logic [31:0] FLAGS_RESET = 32'h0000_0000;
  localparam logic [15:0] CODE_RESET = 16'h0000;
  localparam logic [22:0] HALF_TURN = 23'h40_0000;
  localparam logic [22:0] NEAR_WINDOW = 23'h10_0000;
  localparam int CLEAR_TIME_US = 10;
  localparam int CLK_MHZ = 100;
  localparam int CLEAR_CYCLES = CLEAR_TIME_US * CLK_MHZ;
  typedef enum logic [1:0] {MTC_IDLE, MTC_RUN, MTC_DONE} mtc_state_t;
endpackage

// [mtc_trigger.sv]
`timescale 1ns/1ps
// Purpose: special function start objects and multi-turn clear sequencing
// Assumes: object writes are single-cycle strobes from the fieldbus stack
// Notes: abort answer comes the cycle after the write strobe
// Function
// - new zero set at clockwise-side multi-turn transition of current zone
// - service tool clear raises absolute-clear alarm
// - request is code 0031h then bit9 of start flag 1 rising
// - only a 0-to-1 edge of bit9 starts the function
// - a started function runs to completion regardless of bit9
// - in homing mode attained bit drops when clear starts
// - in homing mode attained bit returns when clear completes
// - setting object is 16-bit read-write, full range
// - start flag 1 is 32-bit read-write, all modes
// - reject with 08000022h on servo-on, busy, incremental, probe, single-turn
// - abort leaves setting object unchanged
module mtc_trigger #(
  parameter int CLEAR_CYCLES = mtc_pkg::CLEAR_CYCLES
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // object dictionary access
  input wire logic i_od_wr,
  input wire logic i_od_rd,
  input wire logic [15:0] i_od_index,
  input wire logic [7:0] i_od_sub,
  input wire logic [31:0] i_od_wdata,
  output logic [31:0] o_od_rdata,
  output logic o_od_ack,
  output logic o_od_abort,
  output logic [31:0] o_od_abort_code,
  // drive state
  input wire logic i_servo_on,
  input wire logic i_incremental_enc,
  input wire logic i_touch_probe_active,
  input wire logic i_single_turn_abs,
  input wire logic i_homing_mode,
  input wire logic i_homing_attained,
  input wire logic i_tool_clear_busy,
  input wire logic i_tool_clear_req,
  input wire logic [22:0] i_single_turn,
  // encoder and status
  output logic o_mt_clear,
  output logic o_zero_clockwise_side,
  output logic o_clear_busy,
  output logic o_clear_done,
  output logic o_abs_clear_alarm,
  output logic o_near_half_turn,
  output logic o_status_attained
);
  mtc_pkg::mtc_state_t state;
  logic [31:0] special_start_flags_a;
  logic [31:0] special_start_flags_b;
  logic [31:0] maker_reserved_word;
  logic [15:0] special_function_code;
  logic [$clog2(CLEAR_CYCLES+1)-1:0] cnt;
  logic running;
  logic start_ok;
  logic reject;
  logic wr_flags_a;
  logic raw_rise;
  logic [31:0] flags_a_next;
  mtc_edge_if eif();

  function automatic logic hit(input logic [15:0] idx, input logic [7:0] sub,
                               input logic [15:0] ti, input logic [7:0] ts);
    hit = (idx == ti) && (sub == ts);
  endfunction

  assign running = (state != mtc_pkg::MTC_IDLE);
  assign wr_flags_a = i_od_wr && hit(i_od_index, i_od_sub, mtc_pkg::IDX_START,
                                     mtc_pkg::SUB_FLAGS_A);
  assign flags_a_next = wr_flags_a ? i_od_wdata : special_start_flags_a;
  assign eif.level = flags_a_next[mtc_pkg::START_BIT];
  assign eif.busy = running;

  mtc_edge_det u_edge (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .eif(eif)
  );

  // clear request checks; a request while our own clear runs is refused too
  assign raw_rise = wr_flags_a && i_od_wdata[mtc_pkg::START_BIT] &&
                    !special_start_flags_a[mtc_pkg::START_BIT];
  assign reject = raw_rise &&
                  (special_function_code == mtc_pkg::FN_MT_CLEAR) &&
                  (running || i_servo_on || i_tool_clear_busy || i_incremental_enc ||
                   i_touch_probe_active || i_single_turn_abs);
  assign start_ok = eif.rise && !reject &&
                    (special_function_code == mtc_pkg::FN_MT_CLEAR);

  // object storage
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      special_start_flags_a <= mtc_pkg::FLAGS_RESET;
      special_start_flags_b <= mtc_pkg::FLAGS_RESET;
      maker_reserved_word <= mtc_pkg::FLAGS_RESET;
    end else if (i_od_wr && i_od_index == mtc_pkg::IDX_START) begin
      case (i_od_sub)
        mtc_pkg::SUB_FLAGS_A: special_start_flags_a <= i_od_wdata;
        mtc_pkg::SUB_FLAGS_B: special_start_flags_b <= i_od_wdata;
        mtc_pkg::SUB_MAKER: maker_reserved_word <= i_od_wdata;
        default: special_start_flags_a <= special_start_flags_a;
      endcase
    end
  end

  // function code: written value kept, cleared on success
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      special_function_code <= mtc_pkg::CODE_RESET;
    end else if (state == mtc_pkg::MTC_DONE) begin
      special_function_code <= mtc_pkg::FN_NONE;
    end else if (i_od_wr && hit(i_od_index, i_od_sub, mtc_pkg::IDX_SETTING,
                                mtc_pkg::SUB_COUNT)) begin
      special_function_code <= i_od_wdata[15:0];
    end
  end

  // clear sequence
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      state <= mtc_pkg::MTC_IDLE;
      cnt <= '0;
    end else begin
      case (state)
        mtc_pkg::MTC_IDLE: begin
          cnt <= '0;
          if (start_ok) begin
            state <= mtc_pkg::MTC_RUN;
          end
        end
        mtc_pkg::MTC_RUN: begin
          cnt <= cnt + 1'b1;
          if (cnt == ($clog2(CLEAR_CYCLES+1))'(CLEAR_CYCLES - 1)) begin
            state <= mtc_pkg::MTC_DONE;
          end
        end
        mtc_pkg::MTC_DONE: state <= mtc_pkg::MTC_IDLE;
        default: state <= mtc_pkg::MTC_IDLE;
      endcase
    end
  end

  // encoder commands and status
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_mt_clear <= 1'b0;
      o_zero_clockwise_side <= 1'b0;
      o_clear_done <= 1'b0;
      o_abs_clear_alarm <= 1'b0;
      o_near_half_turn <= 1'b0;
    end else begin
      o_mt_clear <= start_ok;
      o_zero_clockwise_side <= start_ok;
      o_clear_done <= (state == mtc_pkg::MTC_DONE);
      o_abs_clear_alarm <= i_tool_clear_req;
      o_near_half_turn <= (i_single_turn > mtc_pkg::HALF_TURN - mtc_pkg::NEAR_WINDOW) &&
                          (i_single_turn < mtc_pkg::HALF_TURN + mtc_pkg::NEAR_WINDOW);
    end
  end

  assign o_clear_busy = running;
  // homing attained forced low while clearing in homing mode
  assign o_status_attained = i_homing_attained &&
                             !(i_homing_mode && running);

  // read and answer path
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_od_rdata <= '0;
      o_od_ack <= 1'b0;
      o_od_abort <= 1'b0;
      o_od_abort_code <= '0;
    end else begin
      o_od_ack <= (i_od_wr || i_od_rd);
      o_od_abort <= 1'b0;
      o_od_abort_code <= '0;
      if (reject) begin
        o_od_abort <= 1'b1;
        o_od_abort_code <= mtc_pkg::ABORT_STATE;
      end
      if (i_od_rd) begin
        if (hit(i_od_index, i_od_sub, mtc_pkg::IDX_START, mtc_pkg::SUB_COUNT)) begin
          o_od_rdata <= {24'h00_0000, mtc_pkg::ENTRY_COUNT};
        end else if (hit(i_od_index, i_od_sub, mtc_pkg::IDX_START, mtc_pkg::SUB_FLAGS_A)) begin
          o_od_rdata <= special_start_flags_a;
        end else if (hit(i_od_index, i_od_sub, mtc_pkg::IDX_START, mtc_pkg::SUB_FLAGS_B)) begin
          o_od_rdata <= special_start_flags_b;
        end else if (hit(i_od_index, i_od_sub, mtc_pkg::IDX_START, mtc_pkg::SUB_MAKER)) begin
          o_od_rdata <= maker_reserved_word;
        end else if (hit(i_od_index, i_od_sub, mtc_pkg::IDX_SETTING, mtc_pkg::SUB_COUNT)) begin
          o_od_rdata <= {16'h0000, special_function_code};
        end else begin
          o_od_rdata <= '0;
          o_od_abort <= 1'b1;
          o_od_abort_code <= mtc_pkg::ABORT_NO_OBJECT;
        end
      end
    end
  end

  property p_reject_keeps_code;
    @(posedge i_ref_clk) disable iff (i_srst)
      reject && (state != mtc_pkg::MTC_DONE) |=>
        (special_function_code == $past(special_function_code));
  endproperty
  a_reject_keeps_code: assert property (p_reject_keeps_code) else $error("abort changed code");

  property p_reject_code;
    @(posedge i_ref_clk) disable iff (i_srst)
      reject |=> o_od_abort && o_od_abort_code == mtc_pkg::ABORT_STATE;
  endproperty
  a_reject_code: assert property (p_reject_code) else $error("missing state abort");

  property p_no_start_servo_on;
    @(posedge i_ref_clk) disable iff (i_srst)
      i_servo_on && !running |=> !running;
  endproperty
  a_no_start_servo_on: assert property (p_no_start_servo_on) else $error("started in servo on");

  property p_runs_on;
    @(posedge i_ref_clk) disable iff (i_srst)
      $rose(running) |-> running[*8];
  endproperty
  a_runs_on: assert property (p_runs_on) else $error("clear stopped early");

  property p_done_zero;
    @(posedge i_ref_clk) disable iff (i_srst)
      state == mtc_pkg::MTC_DONE |=> special_function_code == mtc_pkg::FN_NONE;
  endproperty
  a_done_zero: assert property (p_done_zero) else $error("code not zeroed");

  property p_attained_low;
    @(posedge i_ref_clk) disable iff (i_srst)
      i_homing_mode && running |-> !o_status_attained;
  endproperty
  a_attained_low: assert property (p_attained_low) else $error("attained high while clearing");

  property p_attained_back;
    @(posedge i_ref_clk) disable iff (i_srst)
      state == mtc_pkg::MTC_DONE && i_homing_mode |=> (o_status_attained == i_homing_attained);
  endproperty
  a_attained_back: assert property (p_attained_back) else $error("attained not restored");

  property p_start_pulse;
    @(posedge i_ref_clk) disable iff (i_srst)
      start_ok |=> o_mt_clear && o_zero_clockwise_side ##1 !o_mt_clear;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("clear command pulse wrong");
endmodule

// [test_multiturn_clear_trigger.sv]
`timescale 1ns/1ps
// Purpose: self-checking bench for the multi-turn clear trigger
// Assumes: clear length shortened to CLR cycles
// Notes: pulses are counted by a monitor at every rising edge
module test_multiturn_clear_trigger;
  localparam int CLR = 8;
  logic i_ref_clk = 1'b0, i_srst = 1'b1, i_homing_mode = 1'b0, i_homing_attained = 1'b1;
  logic i_tool_clear_req = 1'b0;
  logic [4:0] cond = 5'h00;
  logic [22:0] i_single_turn = 23'h00_0000;
  logic od_wr, od_rd, od_ack, od_abort, mt_clear, zero_side, busy, done, alarm, near, att;
  logic [15:0] od_index;
  logic [7:0] od_sub;
  logic [31:0] od_wdata, od_rdata, od_code, r_data, r_code;
  logic r_ack, r_abort;
  int errors = 0, compares = 0, cycles = 0, mt_n = 0, side_n = 0, busy_n = 0, done_n = 0;
  int bad_n = 0;
  mtc_trigger #(.CLEAR_CYCLES(CLR)) dut (.i_ref_clk(i_ref_clk), .i_srst(i_srst),
    .i_od_wr(od_wr), .i_od_rd(od_rd), .i_od_index(od_index), .i_od_sub(od_sub),
    .i_od_wdata(od_wdata), .o_od_rdata(od_rdata), .o_od_ack(od_ack), .o_od_abort(od_abort),
    .o_od_abort_code(od_code), .i_servo_on(cond[0]), .i_incremental_enc(cond[1]),
    .i_touch_probe_active(cond[2]), .i_single_turn_abs(cond[3]), .i_homing_mode(i_homing_mode),
    .i_homing_attained(i_homing_attained), .i_tool_clear_busy(cond[4]),
    .i_tool_clear_req(i_tool_clear_req), .i_single_turn(i_single_turn), .o_mt_clear(mt_clear),
    .o_zero_clockwise_side(zero_side), .o_clear_busy(busy), .o_clear_done(done),
    .o_abs_clear_alarm(alarm),
    .o_near_half_turn(near), .o_status_attained(att));
  mtc_master m (.i_ref_clk(i_ref_clk), .i_rdata(od_rdata), .i_ack(od_ack), .i_abort(od_abort),
    .i_abort_code(od_code), .o_wr(od_wr), .o_rd(od_rd), .o_index(od_index), .o_sub(od_sub),
    .o_wdata(od_wdata));
  initial begin
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) begin
    cycles++;
    if (mt_clear === 1'b1) mt_n++;
    if (mt_clear === 1'b1 && zero_side === 1'b1) side_n++;
    if (busy === 1'b1) busy_n++;
    if (done === 1'b1) done_n++;
    if (busy === 1'b1 && att !== 1'b0) bad_n++;
    if (cycles == 3000) begin
      errors++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d);
    m.access(1'b1, idx, sub, d, r_data, r_ack, r_abort, r_code);
  endtask
  task automatic rd(input logic [15:0] idx, input logic [7:0] sub);
    m.access(1'b0, idx, sub, 32'h0000_0000, r_data, r_ack, r_abort, r_code);
  endtask
  task automatic t_regs();
    rd(mtc_pkg::IDX_SETTING, mtc_pkg::SUB_COUNT);
    chk(r_data, 32'h0000_0000);
    wr(mtc_pkg::IDX_START, mtc_pkg::SUB_COUNT, 32'h0000_0055);
    chk1(r_ack, 1'b1);
    rd(mtc_pkg::IDX_START, mtc_pkg::SUB_COUNT);
    chk(r_data, 32'h0000_0003);
    rd(mtc_pkg::IDX_START, mtc_pkg::SUB_FLAGS_B);
    chk(r_data, 32'h0000_0000);
    rd(mtc_pkg::IDX_START, mtc_pkg::SUB_MAKER);
    chk(r_data, 32'h0000_0000);
    wr(mtc_pkg::IDX_SETTING, mtc_pkg::SUB_COUNT, 32'h0000_FFFF);
    rd(mtc_pkg::IDX_SETTING, mtc_pkg::SUB_COUNT);
    chk(r_data, 32'h0000_FFFF);
    wr(mtc_pkg::IDX_START, mtc_pkg::SUB_FLAGS_A, 32'hFFFF_FDFF);
    rd(mtc_pkg::IDX_START, mtc_pkg::SUB_FLAGS_A);
    chk(r_data, 32'hFFFF_FDFF);
    wr(mtc_pkg::IDX_START, mtc_pkg::SUB_FLAGS_A, 32'h0000_0000);
    rd(16'h4D02, 8'h00);
    chk(r_code, 32'h0602_0000);
    $display("test regs done");
  endtask
  task automatic t_clear();
    int m0, c0, b0, d0;
    m0 = mt_n;
    c0 = side_n;
    b0 = busy_n;
    d0 = done_n;
    i_homing_mode <= 1'b1;
    cond <= 5'h00;
    wr(mtc_pkg::IDX_SETTING, mtc_pkg::SUB_COUNT, {16'h0000, mtc_pkg::FN_MT_CLEAR});
    wr(mtc_pkg::IDX_START, mtc_pkg::SUB_FLAGS_A, 32'h0000_0200);
    chk1(r_abort, 1'b0);
    chk1(att, 1'b0);
    wr(mtc_pkg::IDX_START, mtc_pkg::SUB_FLAGS_A, 32'h0000_0000);
    wr(mtc_pkg::IDX_START, mtc_pkg::SUB_FLAGS_A, 32'h0000_0200);
    chk1(r_abort, 1'b1);
    for (int i = 0; i < 40 && busy !== 1'b0; i++) @(posedge i_ref_clk) #1;
    @(posedge i_ref_clk) #1;
    chk(32'(mt_n - m0), 32'h1);
    chk(32'(side_n - c0), 32'h1);
    chk(32'(busy_n - b0), 32'(CLR + 1));
    chk(32'(done_n - d0), 32'h1);
    chk(32'(bad_n), 32'h0);
    chk1(att, 1'b1);
    rd(mtc_pkg::IDX_SETTING, mtc_pkg::SUB_COUNT);
    chk(r_data, 32'h0000_0000);
    m0 = mt_n;
    wr(mtc_pkg::IDX_SETTING, mtc_pkg::SUB_COUNT, {16'h0000, mtc_pkg::FN_MT_CLEAR});
    wr(mtc_pkg::IDX_START, mtc_pkg::SUB_FLAGS_A, 32'h0000_0200);
    repeat (3) @(posedge i_ref_clk);
    chk(32'(mt_n - m0), 32'h0);
    wr(mtc_pkg::IDX_START, mtc_pkg::SUB_FLAGS_A, 32'h0000_0000);
    i_srst <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    rd(mtc_pkg::IDX_START, mtc_pkg::SUB_FLAGS_A);
    chk(r_data, 32'h0000_0000);
    $display("test clear done");
  endtask
  task automatic t_reject();
    int m0;
    m0 = mt_n;
    wr(mtc_pkg::IDX_SETTING, mtc_pkg::SUB_COUNT, {16'h0000, mtc_pkg::FN_MT_CLEAR});
    for (int i = 0; i < 5; i++) begin
      cond <= 5'(1 << i);
      wr(mtc_pkg::IDX_START, mtc_pkg::SUB_FLAGS_A, 32'h0000_0200);
      chk1(r_abort, 1'b1);
      chk(r_code, mtc_pkg::ABORT_STATE);
      wr(mtc_pkg::IDX_START, mtc_pkg::SUB_FLAGS_A, 32'h0000_0000);
      rd(mtc_pkg::IDX_SETTING, mtc_pkg::SUB_COUNT);
      chk(r_data, {16'h0000, mtc_pkg::FN_MT_CLEAR});
    end
    cond <= 5'h00;
    chk(32'(mt_n - m0), 32'h0);
    $display("test reject done");
  endtask
  task automatic t_misc();
    logic [22:0] pos [4];
    logic exp [4];
    pos = '{mtc_pkg::HALF_TURN, mtc_pkg::HALF_TURN + mtc_pkg::NEAR_WINDOW,
            mtc_pkg::HALF_TURN + mtc_pkg::NEAR_WINDOW - 23'h1, 23'h00_0000};
    exp = '{1'b1, 1'b0, 1'b1, 1'b0};
    chk1(alarm, 1'b0);
    @(posedge i_ref_clk) i_tool_clear_req <= 1'b1;
    repeat (2) @(posedge i_ref_clk) #1;
    chk1(alarm, 1'b1);
    for (int i = 0; i < 4; i++) begin
      @(posedge i_ref_clk) i_single_turn <= pos[i];
      repeat (2) @(posedge i_ref_clk) #1;
      chk1(near, exp[i]);
    end
    $display("test misc done");
  endtask
  task automatic end_sim();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    t_regs();
    t_clear();
    t_reject();
    t_misc();
    end_sim();
  end
endmodule
